// ==== cmd_source.sv ====
// command source model: mimic switch and supervisory system
// assumes the bank samples one-cycle command pulses on the rising edge
`timescale 1ns/1ns
module cmd_source
  import logic_io_pkg::*;
(
  input wire logic i_core_clk,
  output logic [NUM_BITS-1:0] o_mimic_set_one,
  output logic [NUM_BITS-1:0] o_mimic_set_zero,
  output logic [NUM_BITS-1:0] o_scada_set_one,
  output logic [NUM_BITS-1:0] o_scada_set_zero
);
  // ****************
  // command pulses
  // ****************
  initial begin
    o_mimic_set_one = 32'h0;
    o_mimic_set_zero = 32'h0;
    o_scada_set_one = 32'h0;
    o_scada_set_zero = 32'h0;
  end

  // two command origins
  // one-cycle pulse, released at the next edge so no command lingers
  task automatic send(input logic scada, input logic [NUM_BITS-1:0] one,
      input logic [NUM_BITS-1:0] zero);
    @(posedge i_core_clk);
    #1;
    if (scada) begin
      o_scada_set_one = one;
      o_scada_set_zero = zero;
    end else begin
      o_mimic_set_one = one;
      o_mimic_set_zero = zero;
    end
    @(posedge i_core_clk);
    #1;
    o_mimic_set_one = 32'h0;
    o_mimic_set_zero = 32'h0;
    o_scada_set_one = 32'h0;
    o_scada_set_zero = 32'h0;
  endtask : send
endmodule : cmd_source

// ==== logic_in_cell.sv ====
// one logical input bit with hold or pulse behaviour
// assumes commands are one-cycle pulses synchronous to the core clock
`timescale 1ns/1ns
module logic_in_cell
  import logic_io_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_mode_pulse,
  input wire logic i_set_one,
  input wire logic i_set_zero,
  output logic o_logic_in_bit
);
  logic state_q;
  logic state_d;
  logic [PULSE_CNT_W-1:0] cnt_q;
  logic [PULSE_CNT_W-1:0] cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (i_set_one) begin
      state_d = 1'b1;
      cnt_d = '0;
    end else if (i_set_zero) begin
      state_d = 1'b0;
      cnt_d = '0;
    end else if (i_mode_pulse && state_q) begin
      if (cnt_q == PULSE_LAST) begin
        state_d = 1'b0;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_logic_in_bit = state_q;

  property p_pulse_len;
    @(posedge i_core_clk) disable iff (i_rst)
    (cnt_q == PULSE_LAST && state_q && i_mode_pulse && !i_set_one)
      |=> !state_q;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse did not end on time");

  property p_set_one;
    @(posedge i_core_clk) disable iff (i_rst)
    i_set_one |=> state_q && cnt_q == '0;
  endproperty
  a_set_one: assert property (p_set_one)
    else $error("set did not restart pulse");

  property p_hold_stays;
    @(posedge i_core_clk) disable iff (i_rst)
    (!i_mode_pulse && state_q && !i_set_zero) |=> state_q;
  endproperty
  a_hold_stays: assert property (p_hold_stays)
    else $error("hold input dropped");

  property p_zero;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_set_zero && !i_set_one) |=> !state_q;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero command ignored");

  c_pulse_end: cover property (@(posedge i_core_clk)
    state_q && i_mode_pulse ##1 !state_q);
endmodule : logic_in_cell

// ==== logic_io_bank.sv ====
// bank of 32 logical inputs and 32 logical outputs with event capture
// assumes commands and user logic results are synchronous to the clock
//
// Overview of operation
// - thirty-two logical output bits from user logic
// - outputs routed to blocking, groups, relays, leds
// - output state readable by supervisory system
// - on/off events, only enabled polarities stored
// - each event carries capture time stamp
// - thirty-two inputs set only by commands
// - all inputs zero after every reboot
// - per input mode hold or pulse
// - hold stays one until zero command
// - pulse clears itself after five milliseconds
`timescale 1ns/1ns
module logic_io_bank
  import logic_io_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [NUM_BITS-1:0] i_mimic_set_one,
  input wire logic [NUM_BITS-1:0] i_mimic_set_zero,
  input wire logic [NUM_BITS-1:0] i_scada_set_one,
  input wire logic [NUM_BITS-1:0] i_scada_set_zero,
  input wire logic [NUM_BITS-1:0] i_input_mode_pulse,
  input wire logic [NUM_BITS-1:0] i_user_logic_result,
  input wire logic [NUM_BITS-1:0] i_event_on_enable,
  input wire logic [NUM_BITS-1:0] i_event_off_enable,
  input wire logic [STAMP_W-1:0] i_time_stamp,
  output logic [NUM_BITS-1:0] o_logic_in_bit,
  output logic [NUM_BITS-1:0] o_logic_out_bit,
  output logic [NUM_BITS-1:0] o_logic_out_status,
  output logic o_event_valid,
  output logic o_event_is_on,
  output logic [4:0] o_event_index,
  output logic [STAMP_W-1:0] o_event_stamp,
  output logic o_event_overrun
);
  // ***********************************************
  // logical inputs
  // ***********************************************
  logic [NUM_BITS-1:0] set_one;
  logic [NUM_BITS-1:0] set_zero;

  assign set_one = i_mimic_set_one | i_scada_set_one;
  assign set_zero = i_mimic_set_zero | i_scada_set_zero;

  for (genvar g = 0; g < NUM_BITS; g++) begin : g_in
    logic_in_cell logic_in_cell_i (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_mode_pulse(i_input_mode_pulse[g]),
      .i_set_one(set_one[g]),
      .i_set_zero(set_zero[g]),
      .o_logic_in_bit(o_logic_in_bit[g])
    );
  end

  property p_only_cmd;
    @(posedge i_core_clk) disable iff (i_rst)
    (o_logic_in_bit & ~$past(o_logic_in_bit) & ~$past(set_one)) == '0;
  endproperty
  a_only_cmd: assert property (p_only_cmd)
    else $error("logical input rose without command");

  property p_set_reach;
    @(posedge i_core_clk) disable iff (i_rst)
    (|set_one) |=> (o_logic_in_bit & $past(set_one)) == $past(set_one);
  endproperty
  a_set_reach: assert property (p_set_reach)
    else $error("set command did not reach input");

  // ***********************************************
  // logical outputs and events
  // ***********************************************
  logic [NUM_BITS-1:0] out_q;
  logic [NUM_BITS-1:0] out_d;
  logic [NUM_BITS-1:0] pend_on_q;
  logic [NUM_BITS-1:0] pend_on_d;
  logic [NUM_BITS-1:0] pend_off_q;
  logic [NUM_BITS-1:0] pend_off_d;
  logic [STAMP_W-1:0] stamp_q [NUM_BITS];
  logic [STAMP_W-1:0] stamp_d [NUM_BITS];
  logic ev_valid_q;
  logic ev_valid_d;
  logic ev_on_q;
  logic ev_on_d;
  logic [4:0] ev_idx_q;
  logic [4:0] ev_idx_d;
  logic [STAMP_W-1:0] ev_stamp_q;
  logic [STAMP_W-1:0] ev_stamp_d;
  logic overrun_q;
  logic overrun_d;
  logic [NUM_BITS-1:0] rise;
  logic [NUM_BITS-1:0] fall;

  // on events before off events, lowest pending index wins within each; one event per cycle
  function automatic logic [5:0] first_set(input logic [NUM_BITS-1:0] v);
    logic [5:0] r;
    r = 6'h20;
    for (int i = NUM_BITS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction : first_set

  always_comb begin
    logic [5:0] pick;
    logic pick_on;
    pick = 6'h20;
    pick_on = 1'b0;
    out_d = i_user_logic_result;
    rise = i_user_logic_result & ~out_q;
    fall = ~i_user_logic_result & out_q;
    pend_on_d = pend_on_q;
    pend_off_d = pend_off_q;
    stamp_d = stamp_q;
    ev_valid_d = 1'b0;
    ev_on_d = ev_on_q;
    ev_idx_d = ev_idx_q;
    ev_stamp_d = ev_stamp_q;
    overrun_d = 1'b0;
    if (|pend_on_q) begin
      pick = first_set(pend_on_q);
      pick_on = 1'b1;
    end else if (|pend_off_q) begin
      pick = first_set(pend_off_q);
    end
    if (!pick[5]) begin
      ev_valid_d = 1'b1;
      ev_on_d = pick_on;
      ev_idx_d = pick[4:0];
      ev_stamp_d = stamp_q[pick[4:0]];
      if (pick_on) begin
        pend_on_d[pick[4:0]] = 1'b0;
      end else begin
        pend_off_d[pick[4:0]] = 1'b0;
      end
    end
    for (int i = 0; i < NUM_BITS; i++) begin
      if ((rise[i] && i_event_on_enable[i]) ||
          (fall[i] && i_event_off_enable[i])) begin
        // an unsent event of this bit is replaced; flag it
        if (pend_on_d[i] || pend_off_d[i]) begin
          overrun_d = 1'b1;
        end
        pend_on_d[i] = rise[i];
        pend_off_d[i] = fall[i];
        stamp_d[i] = i_time_stamp;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      out_q <= '0;
      pend_on_q <= '0;
      pend_off_q <= '0;
      for (int i = 0; i < NUM_BITS; i++) begin
        stamp_q[i] <= '0;
      end
      ev_valid_q <= 1'b0;
      ev_on_q <= 1'b0;
      ev_idx_q <= INDEX_W5_ZERO;
      ev_stamp_q <= '0;
      overrun_q <= 1'b0;
    end else begin
      out_q <= out_d;
      pend_on_q <= pend_on_d;
      pend_off_q <= pend_off_d;
      stamp_q <= stamp_d;
      ev_valid_q <= ev_valid_d;
      ev_on_q <= ev_on_d;
      ev_idx_q <= ev_idx_d;
      ev_stamp_q <= ev_stamp_d;
      overrun_q <= overrun_d;
    end
  end

  assign o_logic_out_bit = out_q;
  assign o_logic_out_status = out_q;
  assign o_event_valid = ev_valid_q;
  assign o_event_is_on = ev_on_q;
  assign o_event_index = ev_idx_q;
  assign o_event_stamp = ev_stamp_q;
  assign o_event_overrun = overrun_q;

  // ***********************************************
  // checks
  // ***********************************************
  property p_out_follow;
    @(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> o_logic_out_bit == $past(i_user_logic_result);
  endproperty
  a_out_follow: assert property (p_out_follow)
    else $error("output bit does not follow logic");

  property p_status_eq;
    @(posedge i_core_clk) disable iff (i_rst)
    o_logic_out_status == o_logic_out_bit;
  endproperty
  a_status_eq: assert property (p_status_eq)
    else $error("status differs from output");

  // mask of an index and all bits below it
  function automatic logic [NUM_BITS-1:0] upto_mask(input logic [4:0] idx);
    return (32'h2 << idx) - 32'h1;
  endfunction : upto_mask

  function automatic logic [NUM_BITS-1:0] bit_of(input logic [4:0] idx);
    return 32'h1 << idx;
  endfunction : bit_of

  property p_on_first;
    @(posedge i_core_clk) disable iff (i_rst)
    (o_event_valid && o_event_is_on) |->
      ($past(pend_on_q) & upto_mask(o_event_index))
      == bit_of(o_event_index);
  endproperty
  a_on_first: assert property (p_on_first)
    else $error("on event out of order");

  property p_off_first;
    @(posedge i_core_clk) disable iff (i_rst)
    (o_event_valid && !o_event_is_on) |->
      $past(pend_on_q) == '0
      && ($past(pend_off_q) & upto_mask(o_event_index))
      == bit_of(o_event_index);
  endproperty
  a_off_first: assert property (p_off_first)
    else $error("off event out of order");

  property p_ovr_cause;
    @(posedge i_core_clk) disable iff (i_rst)
    o_event_overrun |->
      $past(|((rise | fall) & (pend_on_q | pend_off_q)));
  endproperty
  a_ovr_cause: assert property (p_ovr_cause)
    else $error("overrun without a pending event");

  property p_in_reset;
    @(posedge i_core_clk) disable iff (i_rst)
    $past(i_rst) |-> o_logic_in_bit == '0 && !o_event_valid
      && o_logic_out_bit == '0;
  endproperty
  a_in_reset: assert property (p_in_reset)
    else $error("state not cleared by reset");

  property p_on_stored;
    @(posedge i_core_clk) disable iff (i_rst)
    (rise[0] && i_event_on_enable[0] && pend_on_q == '0
      && pend_off_q == '0)
      |=> ##1 o_event_valid && o_event_is_on && o_event_index == 5'h00
      && o_event_stamp == $past(i_time_stamp, 2);
  endproperty
  a_on_stored: assert property (p_on_stored)
    else $error("on event lost or stamp wrong");

  property p_off_stored;
    @(posedge i_core_clk) disable iff (i_rst)
    (fall[0] && i_event_off_enable[0] && pend_on_q == '0
      && pend_off_q == '0 && (rise & i_event_on_enable) == '0)
      |=> ##1 o_event_valid && !o_event_is_on && o_event_index == 5'h00
      && o_event_stamp == $past(i_time_stamp, 2);
  endproperty
  a_off_stored: assert property (p_off_stored)
    else $error("off event lost or stamp wrong");

  property p_no_disabled;
    @(posedge i_core_clk) disable iff (i_rst)
    (rise[0] && !i_event_on_enable[0] && !pend_on_q[0]) |=> !pend_on_q[0];
  endproperty
  a_no_disabled: assert property (p_no_disabled)
    else $error("disabled on event stored");

  property p_off_pol;
    @(posedge i_core_clk) disable iff (i_rst)
    (fall[0] && i_event_off_enable[0]) |=> pend_off_q[0] && !pend_on_q[0];
  endproperty
  a_off_pol: assert property (p_off_pol)
    else $error("off event polarity wrong");

  c_on_event: cover property (@(posedge i_core_clk)
    o_event_valid && o_event_is_on);
  c_off_event: cover property (@(posedge i_core_clk)
    o_event_valid && !o_event_is_on);
  c_overrun: cover property (@(posedge i_core_clk) o_event_overrun);
  c_both_cmd: cover property (@(posedge i_core_clk)
    |(set_one & set_zero));
endmodule : logic_io_bank

// ==== logic_io_pkg.sv ====
// constants for the logical input/output signal bank
// assumes a 20 mhz core clock and a free running time base outside
package logic_io_pkg;
  localparam int unsigned NUM_BITS = 32;
  localparam int unsigned STAMP_W = 32;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned PULSE_TIME_US = 5000;
  // least time; 20 cycles per microsecond, so no rounding is needed
  localparam int unsigned PULSE_CYCLES =
    (PULSE_TIME_US * (CLK_HZ / 1000000) + 0) ;
  localparam int unsigned PULSE_CNT_W = 17;
  localparam logic [NUM_BITS-1:0] INPUT_RESET = 32'h0000_0000;
  localparam logic [PULSE_CNT_W-1:0] PULSE_LAST =
    PULSE_CNT_W'(PULSE_CYCLES - 1);
  localparam logic [4:0] INDEX_W5_ZERO = 5'h00;
  typedef enum logic {
    MODE_HOLD,
    MODE_PULSE
  } input_mode_t;
endpackage : logic_io_pkg

// ==== test_logic_io_bank.sv ====
// self-checking testbench for the logical input/output bank
// assumes the command source model drives every command input
`timescale 1ns/1ns
module test_logic_io_bank;
  import logic_io_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [NUM_BITS-1:0] m_one, m_zero, s_one, s_zero, in_bit, out_bit;
  logic [NUM_BITS-1:0] mode = 32'h0, result = 32'h0, out_stat;
  logic [NUM_BITS-1:0] on_en = 32'hffffffff, off_en = 32'h5;
  logic [STAMP_W-1:0] stamp = 32'h0, ev_stamp;
  logic ev_valid, ev_on, ev_ovr;
  logic [4:0] ev_idx;
  logic [37:0] evq[$];
  int num_errors = 0;
  int checked = 0;
  int ovr_seen = 0;

  // ****************
  // clock, time base, event capture
  // ****************
  always #25 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) stamp <= stamp + 32'h1;
  // event stream has no back-pressure, so every valid is logged
  // sampled mid-cycle, away from the edge that launches them
  always @(negedge i_core_clk) begin
    if (ev_valid === 1'b1) evq.push_back({ev_on, ev_idx, ev_stamp});
    if (ev_ovr === 1'b1) ovr_seen++;
  end

  cmd_source cmd_source_i (.i_core_clk(i_core_clk),
    .o_mimic_set_one(m_one), .o_mimic_set_zero(m_zero),
    .o_scada_set_one(s_one), .o_scada_set_zero(s_zero));

  logic_io_bank logic_io_bank_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_mimic_set_one(m_one), .i_mimic_set_zero(m_zero),
    .i_scada_set_one(s_one), .i_scada_set_zero(s_zero),
    .i_input_mode_pulse(mode), .i_user_logic_result(result),
    .i_event_on_enable(on_en), .i_event_off_enable(off_en),
    .i_time_stamp(stamp), .o_logic_in_bit(in_bit),
    .o_logic_out_bit(out_bit), .o_logic_out_status(out_stat),
    .o_event_valid(ev_valid), .o_event_is_on(ev_on),
    .o_event_index(ev_idx), .o_event_stamp(ev_stamp),
    .o_event_overrun(ev_ovr));

  // ****************
  // helpers
  // ****************
  task automatic check(input string what, input logic [37:0] seen,
      input logic [37:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step

  task automatic close_out();
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  // ****************
  // scenarios
  // ****************
  task automatic t_hold();
    cmd_source_i.send(1'b0, 32'h8, 32'h0);
    check("hold set", {6'h00, in_bit}, 38'h8);
    step(20);
    check("hold keep", {6'h00, in_bit}, 38'h8);
    cmd_source_i.send(1'b1, 32'h0, 32'h8);
    check("hold clear", {6'h00, in_bit}, 38'h0);
    cmd_source_i.send(1'b1, 32'hffffffff, 32'hffffffff);
    check("all set", {6'h00, in_bit}, 38'hffffffff);
    cmd_source_i.send(1'b0, 32'h0, 32'hffffffff);
    check("all clear", {6'h00, in_bit}, 38'h0);
  endtask : t_hold

  task automatic t_events();
    logic [STAMP_W-1:0] s;
    logic [STAMP_W-1:0] s2;
    result = 32'h85;
    s = stamp;
    step(1);
    check("out_bit", {6'h00, out_bit}, 38'h85);
    check("out_status", {6'h00, out_stat}, 38'h85);
    step(8);
    check("on count", 38'(evq.size()), 38'h3);
    check("on ev 0", evq[0], {1'b1, 5'h00, s});
    check("on ev 2", evq[1], {1'b1, 5'h02, s});
    check("on ev 7", evq[2], {1'b1, 5'h07, s});
    evq.delete();
    // bit 7 falls with its off polarity disabled
    result = 32'h0;
    s = stamp;
    step(9);
    check("off count", 38'(evq.size()), 38'h2);
    check("off ev 0", evq[0], {1'b0, 5'h00, s});
    check("off ev 2", evq[1], {1'b0, 5'h02, s});
    evq.delete();
    // bit 0 rises with its on polarity disabled
    on_en = 32'hfffffffe;
    result = 32'h1;
    step(9);
    check("masked count", 38'(evq.size()), 38'h0);
    // bit 2 falls before its on event leaves, so it is replaced
    on_en = 32'hffffffff;
    result = 32'h7;
    s = stamp;
    step(1);
    result = 32'h3;
    s2 = stamp;
    step(9);
    check("overrun", 38'(ovr_seen), 38'h1);
    check("repl count", 38'(evq.size()), 38'h2);
    check("repl ev 1", evq[0], {1'b1, 5'h01, s});
    check("repl ev 2", evq[1], {1'b0, 5'h02, s2});
  endtask : t_events

  task automatic t_pulse();
    mode = 32'h1;
    cmd_source_i.send(1'b1, 32'h3, 32'h0);
    check("pulse set", {6'h00, in_bit}, 38'h3);
    // bench logic holds the output past the pulse
    result = 32'h1;
    step(10);
    cmd_source_i.send(1'b0, 32'h1, 32'h0);
    step(99999);
    check("pulse held", {6'h00, in_bit}, 38'h3);
    step(1);
    check("pulse end", {6'h00, in_bit}, 38'h2);
    check("stretched", {6'h00, out_bit}, 38'h1);
    step(20);
    result = 32'h0;
    step(2);
    check("stretch end", {6'h00, out_bit}, 38'h0);
    mode = 32'h0;
  endtask : t_pulse

  task automatic t_reboot();
    cmd_source_i.send(1'b0, 32'h5, 32'h0);
    check("pre reboot", {6'h00, in_bit}, 38'h7);
    i_rst = 1'b1;
    step(1);
    i_rst = 1'b0;
    check("reboot", {6'h00, in_bit}, 38'h0);
  endtask : t_reboot

  // ****************
  // main sequence and watchdog
  // ****************
  initial begin
    step(3);
    i_rst = 1'b0;
    check("reset", {6'h00, in_bit}, 38'h0);
    t_hold();
    t_events();
    t_pulse();
    t_reboot();
    close_out();
  end

  // pulse wait dominates the run, about 100100 cycles
  initial begin
    #6000000;
    num_errors++;
    close_out();
  end
endmodule : test_logic_io_bank
